// ---- common/status_protect_defines.svh ----
// Constants for the status register and block-protection logic.
// Assumes a 10 MHz core clock and a byte-addressed 24-bit array.
`ifndef STATUS_PROTECT_DEFINES_SVH
`define STATUS_PROTECT_DEFINES_SVH

// --------------------------------------------------------------
// Array geometry
// --------------------------------------------------------------
`define ADDR_W            24
`define SECTOR_LSB        16
`define SECTOR_COUNT      256
`define SUB32K_COUNT      512
`define SUB4K_COUNT       4096
`define TOP_ADDR          24'hffffff

// --------------------------------------------------------------
// Status byte field positions
// --------------------------------------------------------------
`define ST_WDIS_BIT       7
`define ST_BPMSB_BIT      6
`define ST_TB_BIT         5
`define ST_BPLO_HI        4
`define ST_BPLO_LO        2
`define ST_WEL_BIT        1
`define ST_WIP_BIT        0

// Flag status byte field positions
`define FS_READY_BIT      7
`define FS_ERASE_ERR_BIT  5
`define FS_PROG_ERR_BIT   4
`define FS_PROT_ERR_BIT   1

// --------------------------------------------------------------
// Reset values
// --------------------------------------------------------------
`define RST_WDIS          1'b0
`define RST_TB            1'b0
`define RST_BP            4'h0
`define RST_WEL           1'b0
`define RST_FLAG_BYTE     8'h80

// --------------------------------------------------------------
// Serial opcodes
// --------------------------------------------------------------
`define OP_WRITE_ENABLE   8'h06
`define OP_WRITE_DISABLE  8'h04
`define OP_READ_STATUS    8'h05
`define OP_WRITE_STATUS   8'h01
`define OP_READ_FLAG      8'h70
`define OP_CLEAR_FLAG     8'h50

// --------------------------------------------------------------
// Timing
// --------------------------------------------------------------
`define MCLK_PERIOD_NS    100
`define WRSR_TIME_NS      5000
`define WRSR_CYCLES \
  ((`WRSR_TIME_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`endif

// ---- common/status_protect_pkg.sv ----
// Types shared by the status register block and its serial port.
// Assumes the constants header is on the include path.
package status_protect_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRSR_BUSY,
    ST_ARRAY_BUSY
  } busy_state_e;

  typedef logic [7:0] byte_t;

endpackage

// ---- logic/serial_cmd_port.sv ----
// Serial command port: samples the link pins on mclk and frames bytes.
// Assumes sclk is far slower than mclk (several samples per phase).
`timescale 1ns/100ps
`include "status_protect_defines.svh"

module serial_cmd_port (
  input  wire logic                       mclk,
  input  wire logic                       rstn,
  input  wire logic                       sclk,
  input  wire logic                       csN,
  input  wire logic                       dqIn,
  input  wire status_protect_pkg::byte_t  statusByte,
  input  wire status_protect_pkg::byte_t  flagByte,
  output logic                            dqOut,
  output logic                            dqOe,
  output logic                            cmdStrobe,
  output status_protect_pkg::byte_t       cmdOpcode,
  output status_protect_pkg::byte_t       cmdData,
  output logic [4:0]                      cmdBits
);
  import status_protect_pkg::*;

  typedef struct packed {
    logic       ckS1;
    logic       ckS2;
    logic       ckPrev;
    logic       csS1;
    logic       csS2;
    logic       csPrev;
    logic       dS1;
    logic       dS2;
    logic [4:0] bitCnt;
    byte_t      shiftIn;
    byte_t      opcode;
    byte_t      dataByte;
    byte_t      shiftOut;
    logic       dqOut;
    logic       dqOe;
    logic       cmdStb;
    byte_t      cmdOp;
    byte_t      cmdDat;
    logic [4:0] cmdLen;
  } port_s;

  port_s stateReg;
  port_s stateNext;

  // ------------------------------------------------------------
  // Framing
  // ------------------------------------------------------------
  always_comb begin
    logic  rise;
    logic  fall;
    logic  isRead;
    byte_t loadByte;
    rise     = 1'b0;
    fall     = 1'b0;
    isRead   = 1'b0;
    loadByte = 8'h00;
    stateNext = stateReg;
    stateNext.ckS1   = sclk;
    stateNext.ckS2   = stateReg.ckS1;
    stateNext.ckPrev = stateReg.ckS2;
    stateNext.csS1   = csN;
    stateNext.csS2   = stateReg.csS1;
    stateNext.csPrev = stateReg.csS2;
    stateNext.dS1    = dqIn;
    stateNext.dS2    = stateReg.dS1;
    stateNext.cmdStb = 1'b0;
    rise   = stateReg.ckS2 & ~stateReg.ckPrev;
    fall   = ~stateReg.ckS2 & stateReg.ckPrev;
    isRead = (stateReg.opcode == `OP_READ_STATUS) ||
             (stateReg.opcode == `OP_READ_FLAG);
    loadByte = (stateReg.opcode == `OP_READ_FLAG) ? flagByte : statusByte;
    if (stateReg.csS2) begin
      stateNext.bitCnt = 5'h00;
      stateNext.dqOe   = 1'b1;
      stateNext.opcode = 8'h00;
      // Commands act on deselect, so a cut-short frame is visible
      if (!stateReg.csPrev) begin
        stateNext.cmdStb = 1'b1;
        stateNext.cmdOp  = stateReg.opcode;
        stateNext.cmdDat = stateReg.dataByte;
        stateNext.cmdLen = stateReg.bitCnt;
      end
    end else begin
      if (rise) begin
        stateNext.shiftIn = {stateReg.shiftIn[6:0], stateReg.dS2};
        // Wrap 31 back to 24 so byte phase keeps cycling on long reads
        stateNext.bitCnt = (stateReg.bitCnt == 5'h1f) ? 5'h18 :
                           stateReg.bitCnt + 5'h01;
        if (stateReg.bitCnt == 5'h07) begin
          stateNext.opcode = {stateReg.shiftIn[6:0], stateReg.dS2};
        end
        if (stateReg.bitCnt == 5'h0f) begin
          stateNext.dataByte = {stateReg.shiftIn[6:0], stateReg.dS2};
        end
      end
      if (fall && isRead && stateReg.bitCnt >= 5'h08) begin
        stateNext.dqOe = 1'b0;
        // Reload each byte so polling sees live busy state
        if (stateReg.bitCnt[2:0] == 3'h0) begin
          stateNext.dqOut    = loadByte[7];
          stateNext.shiftOut = {loadByte[6:0], 1'b0};
        end else begin
          stateNext.dqOut    = stateReg.shiftOut[7];
          stateNext.shiftOut = {stateReg.shiftOut[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      stateReg      <= '0;
      stateReg.ckS1 <= 1'b0;
      stateReg.csS1 <= 1'b1;
      stateReg.csS2 <= 1'b1;
      stateReg.csPrev <= 1'b1;
      stateReg.dqOe <= 1'b1;
    end else begin
      stateReg <= stateNext;
    end
  end

  assign dqOut     = stateReg.dqOut;
  assign dqOe      = stateReg.dqOe;
  assign cmdStrobe = stateReg.cmdStb;
  assign cmdOpcode = stateReg.cmdOp;
  assign cmdData   = stateReg.cmdDat;
  assign cmdBits   = stateReg.cmdLen;

endmodule // serial_cmd_port

// ---- logic/status_reg_block_protect.sv ----
// Status register, flag status and sector block protection.
// Assumes an array controller on mclk that requests program/erase.
`timescale 1ns/100ps
`include "status_protect_defines.svh"

module status_reg_block_protect #(
  parameter int unsigned WRSR_CYCLES = `WRSR_CYCLES
) (
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  input  wire logic                   sclk,
  input  wire logic                   csN,
  input  wire logic                   dqIn,
  input  wire logic                   wpN,
  input  wire logic                   opReq,
  input  wire logic                   opErase,
  input  wire logic                   opBulk,
  input  wire logic [`ADDR_W-1:0]     opAddr,
  input  wire logic                   opDone,
  output logic                        dqOut,
  output logic                        dqOe,
  output logic                        opStart,
  output logic                        opReject,
  output status_protect_pkg::byte_t   statusOut,
  output status_protect_pkg::byte_t   flagOut
);
  import status_protect_pkg::*;

  typedef struct packed {
    logic        wpS1;
    logic        wpS2;
    busy_state_e state;
    logic [15:0] waitCnt;
    logic        wdis;
    logic        topBottom;
    logic [3:0]  blockProtectField;
    logic        wel;
    logic        protErr;
    logic        progErr;
    logic        eraseErr;
    logic        opStart;
    logic        opReject;
    byte_t       statusByte;
    byte_t       flagByte;
  } ctrl_s;

  ctrl_s ctrlReg;
  ctrl_s ctrlNext;

  logic       cmdStrobe;
  byte_t      cmdOpcode;
  byte_t      cmdData;
  logic [4:0] cmdBits;

  // ------------------------------------------------------------
  // Serial link
  // ------------------------------------------------------------
  serial_cmd_port u_port (
    .mclk       (mclk),
    .rstn       (rstn),
    .sclk       (sclk),
    .csN        (csN),
    .dqIn       (dqIn),
    .statusByte (ctrlReg.statusByte),
    .flagByte   (ctrlReg.flagByte),
    .dqOut      (dqOut),
    .dqOe       (dqOe),
    .cmdStrobe  (cmdStrobe),
    .cmdOpcode  (cmdOpcode),
    .cmdData    (cmdData),
    .cmdBits    (cmdBits)
  );

  // ------------------------------------------------------------
  // Protected-sector decode
  // ------------------------------------------------------------
  function automatic logic sectorProtected(
    input logic [3:0] code,
    input logic       bottom,
    input logic [7:0] sector
  );
    logic [8:0] span;
    span = 9'h000;
    if (code == 4'h0) begin
      sectorProtected = 1'b0;
    end else if (code >= 4'h9) begin
      sectorProtected = 1'b1;
    end else begin
      span = 9'h001 << (code - 4'h1);
      if (bottom) begin
        sectorProtected = ({1'b0, sector} < span);
      end else begin
        sectorProtected = ({1'b0, sector} >= (9'h100 - span));
      end
    end
  endfunction

  // ------------------------------------------------------------
  // Control
  // ------------------------------------------------------------
  always_comb begin
    logic       hwLock;
    logic       busy;
    logic [7:0] sector;
    hwLock = 1'b0;
    busy   = 1'b0;
    sector = 8'h00;
    ctrlNext = ctrlReg;
    ctrlNext.wpS1     = wpN;
    ctrlNext.wpS2     = ctrlReg.wpS1;
    ctrlNext.opStart  = 1'b0;
    ctrlNext.opReject = 1'b0;
    // Lock follows the pin level, so raising it or a reset are the only ways out
    hwLock = ctrlReg.wdis & ~ctrlReg.wpS2;
    sector = opAddr[`ADDR_W-1:`SECTOR_LSB];

    if (cmdStrobe && cmdOpcode == `OP_CLEAR_FLAG && cmdBits == 5'h08) begin
      ctrlNext.protErr  = 1'b0;
      ctrlNext.progErr  = 1'b0;
      ctrlNext.eraseErr = 1'b0;
    end

    unique case (ctrlReg.state)
      ST_IDLE: begin
        if (cmdStrobe) begin
          if (cmdOpcode == `OP_WRITE_ENABLE && cmdBits == 5'h08) begin
            ctrlNext.wel = 1'b1;
          end else if (cmdOpcode == `OP_WRITE_DISABLE &&
                       cmdBits == 5'h08) begin
            ctrlNext.wel = 1'b0;
          end else if (cmdOpcode == `OP_WRITE_STATUS &&
                       cmdBits == 5'h10) begin
            if (ctrlReg.wel && !hwLock) begin
              ctrlNext.wdis      = cmdData[`ST_WDIS_BIT];
              ctrlNext.topBottom = cmdData[`ST_TB_BIT];
              ctrlNext.blockProtectField =
                {cmdData[`ST_BPMSB_BIT],
                 cmdData[`ST_BPLO_HI:`ST_BPLO_LO]};
              ctrlNext.state   = ST_WRSR_BUSY;
              ctrlNext.waitCnt = 16'(WRSR_CYCLES);
            end else begin
              ctrlNext.wel = 1'b0;
            end
          end
        end else if (opReq) begin
          if (!ctrlReg.wel) begin
            ctrlNext.opReject = 1'b1;
          end else if (opBulk && ctrlReg.blockProtectField != 4'h0) begin
            ctrlNext.opReject = 1'b1;
            ctrlNext.wel      = 1'b0;
            ctrlNext.protErr  = 1'b1;
            ctrlNext.eraseErr = 1'b1;
          end else if (!opBulk &&
                       sectorProtected(ctrlReg.blockProtectField,
                                       ctrlReg.topBottom, sector)) begin
            ctrlNext.opReject = 1'b1;
            ctrlNext.wel      = 1'b0;
            ctrlNext.protErr  = 1'b1;
            if (opErase) begin
              ctrlNext.eraseErr = 1'b1;
            end else begin
              ctrlNext.progErr = 1'b1;
            end
          end else begin
            ctrlNext.opStart = 1'b1;
            ctrlNext.state   = ST_ARRAY_BUSY;
          end
        end
      end
      ST_WRSR_BUSY: begin
        ctrlNext.waitCnt = ctrlReg.waitCnt - 16'h0001;
        if (ctrlReg.waitCnt <= 16'h0001) begin
          ctrlNext.state = ST_IDLE;
          ctrlNext.wel   = 1'b0;
        end
      end
      ST_ARRAY_BUSY: begin
        if (opDone) begin
          ctrlNext.state = ST_IDLE;
          ctrlNext.wel   = 1'b0;
        end
      end
      default: begin
        ctrlNext.state = ST_IDLE;
      end
    endcase

    // Both bytes derive from one busy term so they never disagree
    busy = (ctrlNext.state != ST_IDLE);
    ctrlNext.statusByte = {ctrlNext.wdis,
                           ctrlNext.blockProtectField[3],
                           ctrlNext.topBottom,
                           ctrlNext.blockProtectField[2:0],
                           ctrlNext.wel,
                           busy};
    ctrlNext.flagByte = {~busy, 1'b0, ctrlNext.eraseErr,
                         ctrlNext.progErr, 2'b00,
                         ctrlNext.protErr, 1'b0};
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ctrlReg                   <= '0;
      ctrlReg.state             <= ST_IDLE;
      ctrlReg.wdis              <= `RST_WDIS;
      ctrlReg.topBottom         <= `RST_TB;
      ctrlReg.blockProtectField <= `RST_BP;
      ctrlReg.wel               <= `RST_WEL;
      ctrlReg.flagByte          <= `RST_FLAG_BYTE;
      ctrlReg.wpS1              <= 1'b1;
      ctrlReg.wpS2              <= 1'b1;
    end else begin
      ctrlReg <= ctrlNext;
    end
  end

  assign opStart   = ctrlReg.opStart;
  assign opReject  = ctrlReg.opReject;
  assign statusOut = ctrlReg.statusByte;
  assign flagOut   = ctrlReg.flagByte;

endmodule // status_reg_block_protect

// ---- verification/serial_host_model.sv ----
// Behavioural host controller on the serial command link.
// Assumes the bench calls xfer; link clock 800 ns, low between frames.
`timescale 1ns/100ps

module serial_host_model (
  output logic      sclk,
  output logic      csN,
  output logic      dqIn,
  input  wire logic dqOut,
  input  wire logic dqOe
);
  import status_protect_pkg::*;

  localparam int HALF_NS = 400;

  initial begin
    sclk = 1'b0;
    csN  = 1'b1;
    dqIn = 1'b1;
  end

  // Opcode then data, MSB first; rd keeps the last eight bits read
  task automatic xfer(input byte_t op, input byte_t dat, input int nBits,
                      output byte_t rd);
    logic [15:0] sr;
    sr = {op, dat};
    rd = 8'h00;
    // Odd offset keeps link edges off the core clock phase
    #37;
    csN = 1'b0;
    for (int i = 0; i < nBits; i++) begin
      dqIn = sr[15 - (i % 16)];
      #(HALF_NS);
      sclk = 1'b1;
      rd = {rd[6:0], dqOe ? 1'bx : dqOut};
      #(HALF_NS);
      sclk = 1'b0;
    end
    #(HALF_NS);
    csN = 1'b1;
    // A released line must not keep showing the last bit
    dqIn = ~dqIn;
  endtask

endmodule // serial_host_model

// ---- verification/status_reg_block_protect_properties.sv ----
// Port-level assertions for the status and sector protection block.
// Assumes it is bound onto status_reg_block_protect; one mclk domain.
`timescale 1ns/100ps
`include "status_protect_defines.svh"

module status_reg_block_protect_properties #(
  parameter int unsigned WRSR_CYCLES = 2
) (
  input wire logic                      mclk,
  input wire logic                      rstn,
  input wire logic                      sclk,
  input wire logic                      csN,
  input wire logic                      dqIn,
  input wire logic                      wpN,
  input wire logic                      opReq,
  input wire logic                      opErase,
  input wire logic                      opBulk,
  input wire logic [`ADDR_W-1:0]        opAddr,
  input wire logic                      opDone,
  input wire logic                      dqOut,
  input wire logic                      dqOe,
  input wire logic                      opStart,
  input wire logic                      opReject,
  input wire status_protect_pkg::byte_t statusOut,
  input wire status_protect_pkg::byte_t flagOut
);
  import status_protect_pkg::*;

  logic [3:0] csHighCnt;
  logic       taken;
  logic [3:0] bp;

  // A request counts only when idle and not already answered
  assign taken = opReq && !statusOut[0] && !opStart && !opReject;
  assign bp    = {statusOut[6], statusOut[4:2]};

  // Cycles since chip select rose, saturating
  always_ff @(posedge mclk) begin
    if (!rstn || !csN) begin
      csHighCnt <= 4'h0;
    end else if (csHighCnt != 4'hf) begin
      csHighCnt <= csHighCnt + 4'h1;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence seqLocked;
    (!wpN)[*5] ##0 statusOut[7];
  endsequence

  sequence seqDoneSeen;
    opDone && statusOut[0] && !opStart;
  endsequence

  a_busy_is_inverse: assert property (statusOut[0] != flagOut[7])
    else $error("busy bit equals ready flag");
  a_reset_clears_all: assert property ($rose(rstn) |->
    statusOut == 8'h00 && flagOut == 8'h80)
    else $error("register not at defaults after reset");
  a_latch_needed: assert property (taken && !statusOut[1] |=>
    opReject && !opStart)
    else $error("request accepted without latch");
  a_start_marks_busy: assert property (opStart |->
    statusOut[0] && !flagOut[7] && !opReject)
    else $error("start without busy");
  a_done_clears_latch: assert property (seqDoneSeen |=>
    !statusOut[0] && !statusOut[1] && flagOut[7])
    else $error("cycle end left busy or latch");
  a_bulk_needs_zero: assert property (taken && opBulk && statusOut[1]
    && bp != 4'h0 |=> opReject ##[0:1] (flagOut[1] && flagOut[5]))
    else $error("bulk erase not refused");
  a_high_code_all: assert property (taken && statusOut[1] && bp > 4'h8
    |=> opReject)
    else $error("request not refused under full protection");
  a_hw_lock_holds: assert property (seqLocked |=> $stable(statusOut[7:2]))
    else $error("locked status bits changed");
  a_flag_until_clear: assert property ($fell(flagOut[1]) |->
    csHighCnt inside {[4'h2:4'hc]})
    else $error("error flag dropped without a command");
  a_idle_releases_dq: assert property (csN[*8] |-> dqOe)
    else $error("data line driven while deselected");

endmodule // status_reg_block_protect_properties

bind status_reg_block_protect status_reg_block_protect_properties #(
  .WRSR_CYCLES(WRSR_CYCLES)
) i_props (
  .mclk(mclk), .rstn(rstn), .sclk(sclk), .csN(csN), .dqIn(dqIn),
  .wpN(wpN), .opReq(opReq), .opErase(opErase), .opBulk(opBulk),
  .opAddr(opAddr), .opDone(opDone), .dqOut(dqOut), .dqOe(dqOe),
  .opStart(opStart), .opReject(opReject), .statusOut(statusOut),
  .flagOut(flagOut)
);

// ---- verification/tb_status_reg_block_protect.sv ----
// Self-checking bench for the status register and sector protection.
// Assumes the host model drives the link; the bench is array controller.
`timescale 1ns/100ps
`include "status_protect_defines.svh"

module tb_status_reg_block_protect;
  import status_protect_pkg::*;

  // Long enough that the busy bit still stands when a command returns
  localparam int unsigned WRSR_CYCLES = 20;
  localparam int TIMEOUT = 90000;

  logic               mclk, sclk, csN, dqIn, dqOut, dqOe, opStart, opReject;
  logic               rstn = 1'b0, wpN = 1'b1, opReq = 1'b0, opErase = 1'b0;
  logic               opBulk = 1'b0, opDone = 1'b0, curTb = 1'b0;
  logic [3:0]         curCode = 4'h0;
  logic [`ADDR_W-1:0] opAddr = '0;
  byte_t              statusOut, flagOut, rd;
  int                 n_errors = 0, check_count = 0, cyc = 0;

  status_reg_block_protect #(.WRSR_CYCLES(WRSR_CYCLES)) i_dut (
    .mclk(mclk), .rstn(rstn), .sclk(sclk), .csN(csN), .dqIn(dqIn),
    .wpN(wpN), .opReq(opReq), .opErase(opErase), .opBulk(opBulk),
    .opAddr(opAddr), .opDone(opDone), .dqOut(dqOut), .dqOe(dqOe),
    .opStart(opStart), .opReject(opReject), .statusOut(statusOut),
    .flagOut(flagOut)
  );

  serial_host_model i_host (
    .sclk(sclk), .csN(csN), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc >= TIMEOUT) begin
      n_errors++;
      final_report();
    end
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input byte_t got, input byte_t exp, input string s);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic cmd(input byte_t op, input byte_t dat, input int nb);
    i_host.xfer(op, dat, nb, rd);
    tick(10);
  endtask

  task automatic wrsr(input byte_t v);
    int k;
    cmd(`OP_WRITE_ENABLE, 8'h00, 8);
    chk(8'(statusOut[1]), 8'h01, "latch set");
    cmd(`OP_WRITE_STATUS, v, 16);
    // Only the locked write runs with the pin low, and it must not start
    chk(8'(statusOut[0]), 8'(wpN), "status write busy");
    k = 0;
    while (statusOut[0] !== 1'b0 && k < 50) begin
      tick(1);
      k++;
    end
  endtask

  function automatic int nProt(input logic [3:0] c);
    return (c == 4'h0) ? 0 : (c > 4'h8) ? 256 : (1 << (c - 4'h1));
  endfunction

  function automatic logic isProt(logic [3:0] c, logic tb, byte_t s);
    return tb ? (int'(s) < nProt(c)) : (int'(s) >= 256 - nProt(c));
  endfunction

  function automatic byte_t sb(logic [3:0] c, logic tb, logic wd);
    return {wd, c[3], tb, c[2:0], 2'b00};
  endfunction

  // Latch, request, then either finish the cycle or inspect the refusal
  task automatic req(input byte_t sec, input logic er, bk, wen);
    logic  acc;
    byte_t exp;
    int    k;
    acc = wen && (bk ? (curCode == 4'h0) : !isProt(curCode, curTb, sec));
    exp = wen ? {2'b10, er, !er, 4'b0010} : 8'h80;
    if (wen) cmd(`OP_WRITE_ENABLE, 8'h00, 8);
    opReq = 1'b1;
    opErase = er;
    opBulk = bk;
    opAddr = {sec, er ? 16'h0000 : 16'hffff};
    k = 0;
    do begin
      tick(1);
      k++;
    end while (!(opStart | opReject) && k < 5);
    opReq = 1'b0;
    chk(8'({opStart, opReject}), 8'({acc, !acc}), "answer");
    if (acc) begin
      chk(statusOut, sb(curCode, curTb, 1'b0) | 8'h03, "busy");
      chk(flagOut, 8'h00, "flags busy");
      tick(3);
      opDone = 1'b1;
      tick(1);
      opDone = 1'b0;
      chk(statusOut, sb(curCode, curTb, 1'b0), "after done");
    end else begin
      tick(20);
      chk(flagOut, exp, "error flags");
      chk(8'(statusOut[1]), 8'h00, "latch after refusal");
      if (wen) begin
        cmd(`OP_CLEAR_FLAG, 8'h00, 8);
        chk(flagOut, 8'h80, "flags cleared");
      end
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    int n;
    tick(20);
    rstn = 1'b1;
    tick(3);
    chk(statusOut, 8'h00, "status reset");
    chk(flagOut, 8'h80, "flags reset");
    chk(8'(dqOe), 8'h01, "link idle");
    req(8'h00, 1'b0, 1'b0, 1'b0);
    cmd(`OP_WRITE_ENABLE, 8'h00, 9);
    chk(statusOut, 8'h00, "long frame ignored");
    cmd(`OP_WRITE_ENABLE, 8'h00, 8);
    chk(statusOut, 8'h02, "latch set");
    cmd(`OP_WRITE_DISABLE, 8'h00, 8);
    chk(statusOut, 8'h00, "latch dropped");
    $display("test reset and latch done");
    for (int t = 0; t < 2; t++) begin
      for (int c = 0; c < 16; c++) begin
        curTb = t[0];
        curCode = c[3:0];
        n = nProt(curCode);
        wrsr(sb(curCode, curTb, 1'b0));
        chk(statusOut, sb(curCode, curTb, 1'b0), "written");
        cmd(`OP_READ_STATUS, 8'h00, 16);
        chk(rd, sb(curCode, curTb, 1'b0), "read status");
        req(8'(256 - n), 1'b0, 1'b0, 1'b1);
        req(8'(255 - n), 1'b1, 1'b0, 1'b1);
        req(8'(n - 1), 1'b0, 1'b0, 1'b1);
        req(8'(n), 1'b1, 1'b0, 1'b1);
        req(8'h00, 1'b1, 1'b1, 1'b1);
      end
    end
    $display("test protection table done");
    curCode = 4'h0;
    curTb = 1'b0;
    wrsr(8'h80);
    chk(statusOut, 8'h80, "disable bit");
    wpN = 1'b0;
    tick(5);
    wrsr(8'h1c);
    chk(statusOut, 8'h80, "locked write");
    wpN = 1'b1;
    tick(5);
    wrsr(8'h1c);
    chk(statusOut, 8'h1c, "unlocked write");
    cmd(`OP_READ_FLAG, 8'h00, 16);
    chk(rd, 8'h80, "read flags");
    $display("test write lock done");
    final_report();
  end

endmodule // tb_status_reg_block_protect
